// *** core/uis_map.svh ***
`ifndef UIS_MAP_SVH
`define UIS_MAP_SVH
// register offsets on the plain register port
`define UIS_OFS_MASK 3'h0
`define UIS_OFS_IDENT 3'h1
`define UIS_OFS_MODE 3'h2
`define UIS_OFS_STATUS 3'h3
`define UIS_OFS_RXTRIG 3'h4
`define UIS_OFS_TXTRIG 3'h5
// mask register fields
`define UIS_MSK_RXDATA 0
`define UIS_MSK_TXEMPTY 1
`define UIS_MSK_RXSTAT 2
`define UIS_MSK_MODEM 3
`define UIS_MSK_SLEEP 4
`define UIS_MSK_SPECIAL 5
`define UIS_MSK_RTS 6
`define UIS_MSK_CTS 7
// mode register fields
`define UIS_MODE_ENH 0
`define UIS_MODE_NINE 1
`define UIS_MODE_ADDR_EN 2
`define UIS_MODE_FIFO_EN 3
`define UIS_MODE_BIGFIFO 4
`define UIS_MODE_EXT_TRIG 5
`define UIS_MODE_LEGACY750 6
`define UIS_MODE_LOOPBACK 7
// identification codes
`define UIS_ID_NONE 6'h01
`define UIS_ID_L1 6'h06
`define UIS_ID_L2A 6'h04
`define UIS_ID_L2B 6'h0c
`define UIS_ID_L3 6'h02
`define UIS_ID_L4 6'h00
`define UIS_ID_L5 6'h10
`define UIS_ID_L6 6'h20
`define UIS_ID_FIFO 2'h3
// time-out in character times
`define UIS_TOUT_CHARS 3'h4
`endif

// *** core/uis_pkg.sv ***
package uis_pkg;
  typedef enum logic [2:0] {
    UIS_LVL_NONE = 3'h0,
    UIS_LVL_1 = 3'h1,
    UIS_LVL_2A = 3'h3,
    UIS_LVL_2B = 3'h2,
    UIS_LVL_3 = 3'h6,
    UIS_LVL_4 = 3'h7,
    UIS_LVL_5 = 3'h5,
    UIS_LVL_6 = 3'h4
  } uis_level_type;
  typedef enum logic [1:0] {
    UIS_AWAKE = 2'h0,
    UIS_ASLEEP = 2'h1
  } uis_sleep_type;
endpackage

// *** core/uis_core.sv ***
`timescale 1ns/1ps
`include "uis_map.svh"
module uis_core #(
  parameter int FIFO_AW = 8
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic char_strobe,
  input wire logic rx_push,
  input wire logic rx_pop,
  input wire logic [FIFO_AW-1:0] rx_level,
  input wire logic rx_overrun,
  input wire logic rx_parity_or_bit9,
  input wire logic rx_framing,
  input wire logic rx_break,
  input wire logic rx_idle,
  input wire logic rx_stop_mid,
  input wire logic [FIFO_AW-1:0] tx_level,
  input wire logic tx_shift_empty,
  input wire logic tx_line_idle,
  input wire logic xoff_match,
  input wire logic second_pause_match,
  input wire logic special_match,
  input wire logic inband_flow_on,
  input wire logic second_pause_en,
  input wire logic [3:0] modem_delta,
  input wire logic modem_status_rd,
  input wire logic cts_pin,
  input wire logic rts_pin,
  input wire logic serial_input_line,
  output logic irq,
  output logic sleep_active,
  output logic line_err_summary
);
  import uis_pkg::*;

  // ==========================================
  // input synchronisers for pins
  logic [1:0] cts_s_q;
  logic [1:0] rts_s_q;
  logic [1:0] serin_s_q;
  logic cts_prev_q;
  logic rts_prev_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cts_s_q <= 2'h0;
      rts_s_q <= 2'h0;
      serin_s_q <= 2'h3;
      cts_prev_q <= 1'b0;
      rts_prev_q <= 1'b0;
    end else begin
      cts_s_q <= {cts_s_q[0], cts_pin};
      rts_s_q <= {rts_s_q[0], rts_pin};
      serin_s_q <= {serin_s_q[0], serial_input_line};
      cts_prev_q <= cts_s_q[1];
      rts_prev_q <= rts_s_q[1];
    end
  end

  // ==========================================
  // software registers
  logic [7:0] mask_q;
  logic [7:0] mode_q;
  logic [FIFO_AW-1:0] rx_trig_q;
  logic [FIFO_AW-1:0] tx_trig_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mask_q <= 8'h00;
      mode_q <= 8'h00;
      rx_trig_q <= '0;
      tx_trig_q <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        `UIS_OFS_MASK: mask_q <= reg_wdata;
        `UIS_OFS_MODE: mode_q <= reg_wdata;
        `UIS_OFS_RXTRIG: rx_trig_q <= FIFO_AW'(reg_wdata);
        `UIS_OFS_TXTRIG: tx_trig_q <= FIFO_AW'(reg_wdata);
        default: ;
      endcase
    end
  end

  logic enh;
  logic nine;
  assign enh = mode_q[`UIS_MODE_ENH];
  assign nine = mode_q[`UIS_MODE_NINE];

  logic id_rd;
  logic ls_rd;
  assign id_rd = reg_rd && (reg_addr == `UIS_OFS_IDENT);
  assign ls_rd = reg_rd && (reg_addr == `UIS_OFS_STATUS);

  // ==========================================
  // line status error flags, set wins over read clear
  logic ovr_q;
  logic par_q;
  logic frm_q;
  logic brk_q;
  logic summ_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ovr_q <= 1'b0;
      par_q <= 1'b0;
      frm_q <= 1'b0;
      brk_q <= 1'b0;
      summ_q <= 1'b0;
    end else begin
      ovr_q <= rx_overrun | (ovr_q & ~ls_rd);
      par_q <= rx_parity_or_bit9 | (par_q & ~ls_rd);
      frm_q <= rx_framing | (frm_q & ~ls_rd);
      brk_q <= rx_break | (brk_q & ~ls_rd);
      // ninth bit sits in the parity position, so it must not count as an error
      summ_q <= (rx_framing | rx_break | (rx_parity_or_bit9 & ~nine)) | (summ_q & ~ls_rd);
    end
  end
  assign line_err_summary = summ_q;

  // ==========================================
  // receive time-out
  logic [2:0] tout_cnt_q;
  logic tout_q;
  logic tout_run_q;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tout_cnt_q <= 3'h0;
      tout_run_q <= 1'b0;
    end else if (rx_push || rx_pop) begin
      tout_cnt_q <= 3'h0;
      tout_run_q <= 1'b0;
    end else if (rx_stop_mid) begin
      tout_run_q <= 1'b1;
    end else if (tout_run_q && char_strobe && tout_cnt_q != `UIS_TOUT_CHARS) begin
      tout_cnt_q <= tout_cnt_q + 3'h1;
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tout_q <= 1'b0;
    end else if (rx_pop || rx_push || !mode_q[`UIS_MODE_FIFO_EN] || rx_level == '0) begin
      tout_q <= 1'b0;
    end else if (tout_run_q && char_strobe && tout_cnt_q == `UIS_TOUT_CHARS - 3'h1) begin
      tout_q <= 1'b1;
    end
  end

  // ==========================================
  // level sources
  logic rx_err_any;
  logic src1;
  logic src2a;
  logic src4;
  logic tx_below;
  logic tx_below_prev_q;
  logic tx_q;
  logic l5_q;
  logic l6_q;
  logic l5_set;
  uis_level_type lvl;

  assign rx_err_any = ovr_q | par_q | frm_q | brk_q;
  assign src1 = nine ?
    (((ovr_q | frm_q | brk_q) & mask_q[`UIS_MSK_MODEM])
     | (par_q & mode_q[`UIS_MODE_ADDR_EN])) :
    (rx_err_any & mask_q[`UIS_MSK_RXSTAT]);
  assign src2a = (rx_level > rx_trig_q) & mask_q[`UIS_MSK_RXDATA];
  assign src4 = (|modem_delta) & mask_q[`UIS_MSK_MODEM];

  // zero extended trigger waits for a drained shifter and idle line
  assign tx_below = (mode_q[`UIS_MODE_EXT_TRIG] && tx_trig_q == '0) ?
    (tx_level == '0 && tx_shift_empty && tx_line_idle) : (tx_level < tx_trig_q);

  assign l5_set = enh & mask_q[`UIS_MSK_SPECIAL] & (nine ? special_match :
    ((xoff_match & inband_flow_on) | (second_pause_match & second_pause_en)));

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_below_prev_q <= 1'b0;
      tx_q <= 1'b0;
    end else begin
      tx_below_prev_q <= tx_below;
      if (tx_below && !tx_below_prev_q) begin
        tx_q <= 1'b1;
      end else if (!tx_below || (id_rd && lvl == UIS_LVL_3)) begin
        tx_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      l5_q <= 1'b0;
    end else if (l5_set) begin
      l5_q <= 1'b1;
    end else if (id_rd && lvl == UIS_LVL_5 || !enh) begin
      l5_q <= 1'b0;
    end
  end

  logic edge6;
  assign edge6 = (cts_s_q[1] & ~cts_prev_q & (~enh | mask_q[`UIS_MSK_CTS]))
    | (rts_s_q[1] & ~rts_prev_q & (~enh | mask_q[`UIS_MSK_RTS]));
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      l6_q <= 1'b0;
    end else if (enh && edge6) begin
      l6_q <= 1'b1;
    end else if (id_rd && lvl == UIS_LVL_6 || !enh) begin
      l6_q <= 1'b0;
    end
  end

  // ==========================================
  // priority encoder
  always_comb begin
    if (src1) lvl = UIS_LVL_1;
    else if (src2a) lvl = UIS_LVL_2A;
    else if (tout_q && mask_q[`UIS_MSK_RXDATA]) lvl = UIS_LVL_2B;
    else if (tx_q && mask_q[`UIS_MSK_TXEMPTY]) lvl = UIS_LVL_3;
    else if (src4) lvl = UIS_LVL_4;
    else if (l5_q && enh) lvl = UIS_LVL_5;
    else if (l6_q && enh) lvl = UIS_LVL_6;
    else lvl = UIS_LVL_NONE;
  end

  function automatic logic [5:0] uis_code(input uis_level_type l);
    case (l)
      UIS_LVL_1: uis_code = `UIS_ID_L1;
      UIS_LVL_2A: uis_code = `UIS_ID_L2A;
      UIS_LVL_2B: uis_code = `UIS_ID_L2B;
      UIS_LVL_3: uis_code = `UIS_ID_L3;
      UIS_LVL_4: uis_code = `UIS_ID_L4;
      UIS_LVL_5: uis_code = `UIS_ID_L5;
      UIS_LVL_6: uis_code = `UIS_ID_L6;
      default: uis_code = `UIS_ID_NONE;
    endcase
  endfunction

  logic [7:0] ident;
  always_comb begin
    ident[5:0] = uis_code(lvl);
    if (mode_q[`UIS_MODE_LEGACY750] && !enh) begin
      ident[5] = mode_q[`UIS_MODE_BIGFIFO];
    end else if (!enh) begin
      ident[5] = 1'b0;
    end
    ident[7:6] = mode_q[`UIS_MODE_FIFO_EN] ? `UIS_ID_FIFO : 2'h0;
  end

  assign irq = (lvl != UIS_LVL_NONE);

  // ==========================================
  // sleep control
  logic sleep_req;
  logic sleep_ok;
  uis_sleep_type sleep_q;
  // legacy non-enhanced framing takes the alternate sleep bit too
  assign sleep_req = mask_q[`UIS_MSK_SLEEP]
    | (mask_q[`UIS_MSK_SPECIAL] & mode_q[`UIS_MODE_LEGACY750] & ~enh & ~nine);
  assign sleep_ok = sleep_req && tx_level == '0 && tx_shift_empty && serin_s_q[1]
    && rx_idle && rx_level == '0
    && !mode_q[`UIS_MODE_LOOPBACK] && modem_delta == 4'h0 && !irq;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sleep_q <= UIS_AWAKE;
    end else begin
      case (sleep_q)
        UIS_AWAKE: if (sleep_ok) sleep_q <= UIS_ASLEEP;
        UIS_ASLEEP: if (!sleep_ok) sleep_q <= UIS_AWAKE;
        default: sleep_q <= UIS_AWAKE;
      endcase
    end
  end
  assign sleep_active = (sleep_q == UIS_ASLEEP);

  // ==========================================
  // read data, one cycle after the strobe
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `UIS_OFS_MASK: reg_rdata <= mask_q;
        `UIS_OFS_IDENT: reg_rdata <= ident;
        `UIS_OFS_MODE: reg_rdata <= mode_q;
        `UIS_OFS_STATUS: reg_rdata <= {summ_q, sleep_active, 2'h0, brk_q, frm_q, par_q, ovr_q};
        `UIS_OFS_RXTRIG: reg_rdata <= 8'(rx_trig_q);
        `UIS_OFS_TXTRIG: reg_rdata <= 8'(tx_trig_q);
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

// *** tb/uis_core_checker.sv ***
`timescale 1ns/1ps
`include "uis_map.svh"
// ==========
// interrupt checker
module uis_core_checker #(
  parameter int FIFO_AW = 8
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic rx_framing,
  input wire logic rx_break,
  input wire logic [FIFO_AW-1:0] rx_level,
  input wire logic [FIFO_AW-1:0] tx_level,
  input wire logic tx_shift_empty,
  input wire logic [3:0] modem_delta,
  input wire logic irq,
  input wire logic sleep_active,
  input wire logic line_err_summary
);
  logic [7:0] msk_q;
  logic [7:0] mode_q;
  logic [FIFO_AW-1:0] rxt_q;
  // shadow copies so the checker knows the programmed modes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      msk_q <= 8'h00;
      mode_q <= 8'h00;
      rxt_q <= '0;
    end else if (reg_wr) begin
      if (reg_addr == `UIS_OFS_MASK) msk_q <= reg_wdata;
      if (reg_addr == `UIS_OFS_MODE) mode_q <= reg_wdata;
      if (reg_addr == `UIS_OFS_RXTRIG) rxt_q <= reg_wdata[FIFO_AW-1:0];
    end
  end
  logic sleep_cond;
  logic frm_brk;
  // plain nets, so that $past only ever looks at one signal
  assign sleep_cond = rx_level == '0 && tx_level == '0 && tx_shift_empty
    && modem_delta == 4'h0 && !irq && !mode_q[7];
  assign frm_brk = rx_framing | rx_break;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence s_id_rd;
    reg_rd && reg_addr == `UIS_OFS_IDENT;
  endsequence
  a_ident_pending: assert property (s_id_rd |=> reg_rdata[0] == !$past(irq))
    else $error("ident bit0 disagrees with irq");
  a_fifo_mirror: assert property (s_id_rd |=> reg_rdata[7:6] == {2{$past(mode_q[3])}})
    else $error("ident fifo bits wrong");
  a_no_enh_lvl: assert property (s_id_rd ##0 !mode_q[0] |=> !reg_rdata[4])
    else $error("level five seen outside enhanced");
  a_bit5_legacy: assert property (s_id_rd ##0 !mode_q[0] |=>
    reg_rdata[5] == ($past(mode_q[6]) && $past(mode_q[4])))
    else $error("ident bit5 wrong");
  a_masked_quiet: assert property (msk_q == 8'h00 && mode_q[2:0] == 3'h0 |-> !irq)
    else $error("irq with all sources masked");
  a_rxdata_irq: assert property (msk_q[0] && rx_level > rxt_q |-> ##[0:2] irq)
    else $error("receive data irq missing");
  a_modem_irq: assert property (msk_q[3] && modem_delta != 4'h0 |-> ##[0:2] irq)
    else $error("modem irq missing");
  a_sleep_entry: assert property (sleep_active |-> $past(sleep_cond))
    else $error("sleep without its conditions");
  a_nine_summary: assert property ($rose(line_err_summary) && mode_q[1] |->
    $past(frm_brk))
    else $error("summary set by other error");
endmodule
bind uis_core uis_core_checker #(.FIFO_AW(FIFO_AW)) chk (.mclk, .arst_n, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_framing, .rx_break, .rx_level, .tx_level,
  .tx_shift_empty, .modem_delta, .irq, .sleep_active, .line_err_summary);

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  // ==========
  // signals
  logic mclk, arst_n, reg_wr, reg_rd;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v, rx_level, tx_level, lv;
  logic [3:0] modem_delta;
  logic [11:0] pv;
  logic irq, sleep_active, line_err_summary;
  int bad_count, n_checks;
  uis_core dut (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .char_strobe(pv[0]), .rx_push(pv[1]), .rx_pop(pv[2]), .rx_level, .rx_overrun(pv[3]),
    .rx_parity_or_bit9(pv[4]), .rx_framing(pv[5]), .rx_break(pv[6]), .rx_idle(lv[0]),
    .rx_stop_mid(pv[7]), .tx_level, .tx_shift_empty(lv[1]), .tx_line_idle(lv[2]),
    .xoff_match(pv[8]), .second_pause_match(pv[9]), .special_match(pv[10]),
    .inband_flow_on(lv[3]), .second_pause_en(lv[4]), .modem_delta, .modem_status_rd(pv[11]),
    .cts_pin(lv[5]), .rts_pin(lv[6]), .serial_input_line(lv[7]), .irq, .sleep_active,
    .line_err_summary);
  // ==========
  // shared tasks
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    // read data stand only in the cycle after the strobe: take them at its closing edge
    @(posedge mclk);
    v = reg_rdata;
  endtask
  task automatic id(input logic [7:0] e);
    rd(3'h1);
    chk(v, e);
  endtask
  task automatic pulse(input int i);
    @(posedge mclk);
    pv[i] <= 1'b1;
    @(posedge mclk);
    pv[i] <= 1'b0;
  endtask
  // pins pass a two-flop synchroniser, so give them a few cycles
  task automatic settle;
    repeat (5) @(posedge mclk);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_prio;
    id(8'h01);
    rd(3'h7);
    chk(v, 8'h00);
    wr(3'h0, 8'h0d);
    modem_delta <= 4'h1;
    settle;
    id(8'h00);
    chk({7'h0, irq}, 8'h01);
    rx_level <= 8'h05;
    settle;
    id(8'h04);
    pulse(5);
    settle;
    id(8'h06);
    rd(3'h3);
    chk(v & 8'h04, 8'h04);
    id(8'h04);
    rx_level <= 8'h00;
    modem_delta <= 4'h0;
    pulse(11);
    settle;
    id(8'h01);
    chk({7'h0, irq}, 8'h00);
    $display("priority done");
  endtask
  task automatic t_nine;
    wr(3'h2, 8'h02);
    wr(3'h0, 8'h08);
    pulse(5);
    settle;
    id(8'h06);
    chk({7'h0, line_err_summary}, 8'h01);
    rd(3'h3);
    pulse(4);
    settle;
    chk({7'h0, line_err_summary}, 8'h00);
    id(8'h01);
    rd(3'h3);
    wr(3'h2, 8'h06);
    pulse(4);
    settle;
    id(8'h06);
    rd(3'h3);
    $display("nine-bit done");
  endtask
  task automatic t_tx;
    wr(3'h5, 8'h04);
    wr(3'h0, 8'h02);
    tx_level <= 8'h08;
    settle;
    tx_level <= 8'h02;
    settle;
    id(8'h02);
    id(8'h01);
    tx_level <= 8'h00;
    wr(3'h5, 8'h00);
    lv[2] <= 1'b0;
    wr(3'h2, 8'h20);
    settle;
    id(8'h01);
    lv[2] <= 1'b1;
    settle;
    id(8'h02);
    wr(3'h2, 8'h00);
    $display("transmit done");
  endtask
  task automatic t_enh;
    wr(3'h2, 8'h01);
    wr(3'h0, 8'h20);
    lv[3] <= 1'b1;
    pulse(8);
    settle;
    id(8'h10);
    id(8'h01);
    wr(3'h0, 8'h00);
    pulse(8);
    id(8'h01);
    wr(3'h2, 8'h03);
    wr(3'h0, 8'h20);
    pulse(10);
    settle;
    id(8'h10);
    wr(3'h0, 8'hc0);
    for (int i = 5; i < 7; i++) begin
      lv[i] <= 1'b1;
      settle;
      id(8'h20);
      id(8'h01);
    end
    lv[6:5] <= 2'h0;
    wr(3'h0, 8'h40);
    lv[5] <= 1'b1;
    settle;
    id(8'h01);
    lv[5] <= 1'b0;
    wr(3'h0, 8'h80);
    lv[6] <= 1'b1;
    settle;
    id(8'h01);
    lv[6] <= 1'b0;
    wr(3'h2, 8'h00);
    lv[6] <= 1'b1;
    settle;
    id(8'h01);
    lv[6] <= 1'b0;
    $display("enhanced done");
  endtask
  task automatic t_fifo;
    wr(3'h2, 8'h58);
    id(8'he1);
    wr(3'h2, 8'h48);
    id(8'hc1);
    wr(3'h4, 8'h08);
    wr(3'h0, 8'h01);
    rx_level <= 8'h01;
    pulse(1);
    pulse(7);
    repeat (3) pulse(0);
    id(8'hc1);
    pulse(0);
    settle;
    id(8'hcc);
    pulse(2);
    rx_level <= 8'h00;
    settle;
    id(8'hc1);
    wr(3'h0, 8'h00);
    wr(3'h2, 8'h00);
    $display("fifo done");
  endtask
  task automatic t_sleep;
    wr(3'h0, 8'h10);
    settle;
    chk({7'h0, sleep_active}, 8'h01);
    lv[7] <= 1'b0;
    settle;
    chk({7'h0, sleep_active}, 8'h00);
    lv[7] <= 1'b1;
    wr(3'h2, 8'h40);
    wr(3'h0, 8'h20);
    settle;
    chk({7'h0, sleep_active}, 8'h01);
    wr(3'h0, 8'h00);
    settle;
    chk({7'h0, sleep_active}, 8'h00);
    $display("sleep done");
  endtask
  // ==========
  // clock, reset, run
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    complete_run;
  end
  initial begin
    {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata, pv} = '0;
    {rx_level, tx_level, modem_delta} = '0;
    lv = 8'h87;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    t_prio;
    t_nine;
    t_tx;
    t_enh;
    t_fifo;
    t_sleep;
    complete_run;
  end
endmodule
